/* File: bench/flash_mode_control_tb.sv */
// self-checking bench: controller against the flash model
`timescale 1ns/1ps
module flash_mode_control_tb;
   localparam flash_ctl_pkg::op_t PRG = flash_ctl_pkg::OP_PROGRAM;
   logic               clk_i = 1'b0;
   logic               rst_i = 1'b1;
   logic               cmd_valid = 1'b0;
   logic               slow = 1'b0;
   flash_ctl_pkg::op_t op = flash_ctl_pkg::OP_READ;
   logic        [19:0] addr = 20'h00000;
   logic        [15:0] data = 16'h0000;
   logic        [38:0] prot = 39'h0;
   logic               ready, rsp_v, rsp_err, sp_mode, vpp, rdy;
   logic               ce_n, og_n, ws_n, rst_n, dq_oe;
   logic        [15:0] rsp_data, dq_o, mdq;
   logic        [19:0] fl_addr;
   int                 fail_count = 0;
   int                 n_checks = 0;
   int                 pulses = 0;
   int                 bad_vpp = 0;
   int                 clash = 0;
   realtime            t0, low_ns;
   wire         [15:0] dq_bus = dq_oe ? dq_o : mdq;
   wire         [7:0]  idle = {ce_n, og_n, ws_n, rst_n, dq_oe, vpp,
                               sp_mode, ready};
   // clock at 125 MHz
   initial forever #4 clk_i = ~clk_i;
   flash_mode_control i_flash_mode_control (
      .CLK_I(clk_i), .RST_I(rst_i), .CMD_VALID_I(cmd_valid),
      .CMD_OP_I(op), .CMD_ADDR_I(addr), .CMD_DATA_I(data),
      .PROTECT_I(prot), .CMD_READY_O(ready), .RSP_VALID_O(rsp_v),
      .RSP_ERROR_O(rsp_err), .RSP_DATA_O(rsp_data), .SP_MODE_O(sp_mode),
      .FL_ADDR_O(fl_addr), .FL_CE_N_O(ce_n), .FL_OUTPUT_GATE_N_O(og_n),
      .FL_WRITE_STROBE_N_O(ws_n), .FL_RESET_N_O(rst_n),
      .FL_VPP_EN_O(vpp), .FL_DQ_I(dq_bus), .FL_DQ_O(dq_o),
      .FL_DQ_OE_O(dq_oe), .FL_RDY_I(rdy));
   flash_model i_flash_model (
      .ce_n_i(ce_n), .og_n_i(og_n), .ws_n_i(ws_n), .rst_n_i(rst_n),
      .vpp_i(vpp), .addr_i(fl_addr), .dq_i(dq_o), .dq_oe_i(dq_oe),
      .dq_o(mdq), .rdy_o(rdy), .lock_i(prot), .slow_i(slow));
   // strobe count, supply and bus clash watch
   always @(negedge ws_n) begin
      pulses++;
      if (!vpp) bad_vpp++;
   end
   always @(posedge clk_i) if (dq_oe && !og_n && !ce_n) clash++;
   always @(negedge rst_n) t0 = $realtime;
   always @(posedge rst_n) low_ns = $realtime - t0;
   task automatic chk(input string what, input logic [31:0] seen,
                      input logic [31:0] exp);
      n_checks++;
      if (seen !== exp) begin
         fail_count++;
         $display("MISMATCH %s expected %h seen %h", what, exp, seen);
      end
   endtask : chk
   task automatic tally_and_finish;
      $display("checks %0d mismatches %0d", n_checks, fail_count);
      if (fail_count == 0 && n_checks > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask : tally_and_finish
   // one request, bounded wait for the answer pulse
   task automatic cmd(input flash_ctl_pkg::op_t o, input logic [19:0] a,
                      input logic [15:0] d, input logic e);
      int i;
      @(posedge clk_i);
      cmd_valid <= 1'b1;
      op        <= o;
      addr      <= a;
      data      <= d;
      @(posedge clk_i);
      cmd_valid <= 1'b0;
      #1;  // a refusal answers at the take edge itself
      for (i = 0; i < 5000 && rsp_v !== 1'b1; i++) begin
         @(posedge clk_i);
         #1;
      end
      if (i == 5000) begin
         fail_count++;
         tally_and_finish();
      end
      chk("refused", rsp_err, e);
      chk("ready", ready, 1'b1);
   endtask : cmd
   task automatic rd(input logic [19:0] a, input logic [15:0] exp);
      cmd(flash_ctl_pkg::OP_READ, a, 16'h0000, 1'b0);
      chk("read data", rsp_data, exp);
   endtask : rd
   task automatic lock(input int n, input logic v);
      @(posedge clk_i);
      prot[n] <= v;
   endtask : lock
   task automatic t_reset;
      @(posedge clk_i);
      #1;
      chk("idle pins", idle, 8'hF1);
      rd(20'h00000, 16'hFFFF);
      $display("test reset done");
   endtask : t_reset
   task automatic t_program;
      pulses = 0;
      cmd(PRG, 20'h12345, 16'hA5C3, 1'b0);
      chk("pulses", pulses, 32'h4);
      rd(20'h12345, 16'hA5C3);
      slow <= 1'b1;  // slow device: answer must wait for ready
      cmd(PRG, 20'h12346, 16'h0F0F, 1'b0);
      slow <= 1'b0;
      rd(20'h12346, 16'h0F0F);
      chk("low supply", bad_vpp, 32'h0);
      chk("clash", clash, 32'h0);
      $display("test program done");
   endtask : t_program
   task automatic t_protect;
      lock(9, 1'b1);
      pulses = 0;
      cmd(PRG, 20'h12347, 16'h0000, 1'b1);
      cmd(flash_ctl_pkg::OP_SECTOR_ERASE, 20'h12000, 16'h0000, 1'b1);
      chk("pulses", pulses, 32'h0);
      lock(9, 1'b0);
      rd(20'h12347, 16'hFFFF);
      $display("test protect done");
   endtask : t_protect
   task automatic t_erase;
      cmd(PRG, 20'h07FFF, 16'h1234, 1'b0);
      cmd(PRG, 20'h08000, 16'h5678, 1'b0);
      cmd(flash_ctl_pkg::OP_SECTOR_ERASE, 20'h07000, 16'h0000, 1'b0);
      rd(20'h07FFF, 16'hFFFF);
      rd(20'h08000, 16'h5678);
      lock(8, 1'b1);
      pulses = 0;
      cmd(flash_ctl_pkg::OP_CHIP_ERASE, 20'h00000, 16'h0000, 1'b0);
      chk("pulses", pulses, 32'h6);
      rd(20'h08000, 16'h5678);
      rd(20'h12345, 16'hFFFF);
      lock(8, 1'b0);
      pulses = 0;
      cmd(flash_ctl_pkg::OP_SUSPEND, 20'h08000, 16'h0000, 1'b0);
      cmd(flash_ctl_pkg::OP_RESUME, 20'h08000, 16'h0000, 1'b0);
      chk("pulses", pulses, 32'h2);
      rd(20'h08000, 16'h5678);
      $display("test erase done");
   endtask : t_erase
   // enter code comes from the controller package, sent here by OP_ENTER_SP
   task automatic t_single;
      flash_ctl_pkg::op_t bar [4];
      bar = '{flash_ctl_pkg::OP_SECTOR_ERASE, flash_ctl_pkg::OP_SUSPEND,
              flash_ctl_pkg::OP_RESUME, flash_ctl_pkg::OP_ENTER_SP};
      cmd(flash_ctl_pkg::OP_ENTER_SP, 20'h00000, 16'h0000, 1'b0);
      chk("single mode", sp_mode, 1'b1);
      pulses = 0;
      cmd(PRG, 20'h00010, 16'hBEEF, 1'b0);
      rd(20'h00010, 16'hBEEF);
      foreach (bar[i]) cmd(bar[i], 20'h00010, 16'h0000, 1'b1);
      chk("pulses", pulses, 32'h1);
      cmd(flash_ctl_pkg::OP_RESET, 20'h00000, 16'h0000, 1'b0);
      chk("reset width", low_ns >= 500.0, 1'b1);
      chk("single mode", sp_mode, 1'b0);
      pulses = 0;
      cmd(PRG, 20'h00011, 16'h00C3, 1'b0);
      chk("pulses", pulses, 32'h4);
      rd(20'h00011, 16'h00C3);
      $display("test single pulse done");
   endtask : t_single
   // reset for eight cycles, then the scenarios in turn
   initial begin
      repeat (8) @(posedge clk_i);
      rst_i <= 1'b0;
      t_reset();
      t_program();
      t_protect();
      t_erase();
      t_single();
      tally_and_finish();
   end
endmodule : flash_mode_control_tb

/* File: bench/flash_model.sv */
// behavioural flash device model facing the controller pins
`timescale 1ns/1ps
module flash_model #(
   parameter int PROG_NS  = 800,
   parameter int ERASE_NS = 2400
) (
   // flash pins
   input  wire logic        ce_n_i,
   input  wire logic        og_n_i,
   input  wire logic        ws_n_i,
   input  wire logic        rst_n_i,
   input  wire logic        vpp_i,
   input  wire logic [19:0] addr_i,
   input  wire logic [15:0] dq_i,
   input  wire logic        dq_oe_i,
   output logic      [15:0] dq_o,
   output logic             rdy_o,
   // lockout and pace
   input  wire logic [38:0] lock_i,
   input  wire logic        slow_i
);
   logic [15:0] mem [int];          // sparse array of 16-bit words
   logic [19:0] a_lat;
   logic [15:0] q = 16'h5A5A;
   logic        sp = 1'b0;
   logic        susp = 1'b0;
   int          s = 0;              // powers up in read mode
   int          busy_ns;
   realtime     t_low;
   event        go;
   wire         wr = !ce_n_i && !ws_n_i && og_n_i && rst_n_i;
   wire         rd = !ce_n_i && !og_n_i && ws_n_i && rst_n_i;
   initial rdy_o = 1'b1;
   // unwritten words read as erased
   function automatic logic [15:0] peek(input logic [19:0] a);
      return mem.exists(int'(a)) ? mem[int'(a)] : 16'hFFFF;
   endfunction : peek
   // bottom boot: eight 4K sectors, then 32K sectors
   function automatic int sect(input logic [19:0] a);
      return (a < 20'h08000) ? int'(a[14:12]) : int'(a[19:15]) + 7;
   endfunction : sect
   task automatic start(input int t);
      busy_ns = slow_i ? 4 * t : t;
      ->go;
   endtask : start
   // locked sectors survive, a locked target ends at once
   task automatic erase(input int n, input logic all);
      if (!vpp_i || (!all && lock_i[n])) return;
      foreach (mem[k])
         if ((all || sect(20'(k)) == n) && !lock_i[sect(20'(k))])
            mem[k] = 16'hFFFF;
      start(ERASE_NS);
   endtask : erase
   task automatic prog(input logic [19:0] a, input logic [15:0] d);
      if (!vpp_i || lock_i[sect(a)]) return;
      mem[int'(a)] = peek(a) & d;              // bits only go to zero
      start(PROG_NS);
   endtask : prog
   task automatic take(input logic [19:0] a, input logic [15:0] d);
      logic [7:0] c;
      c = d[7:0];
      if (!rdy_o) return;
      if (sp) prog(a, d);
      else if (s == 0 && c == 8'hB0) susp = 1'b1;
      else if (s == 0 && susp && c == 8'h30) susp = 1'b0;
      else case (s)
         0: s = (a == 20'h00555 && c == 8'hAA) ? 1 : 0;
         1: s = (a == 20'h002AA && c == 8'h55) ? 2 : 0;
         2: s = (c == 8'hA0) ? 6 : (c == 8'h80) ? 3 : 0;
         3: s = (c == 8'hAA) ? 4 : 0;
         4: s = (c == 8'h55) ? 5 : 0;
         5: begin
            if (c == 8'h30) erase(sect(a), 1'b0);
            if (c == 8'h10) erase(0, 1'b1);
            sp = (c == 8'h50);
            s  = 0;
         end
         default: begin
            prog(a, d);
            s = 0;
         end
      endcase
   endtask : take
   // address at the later fall, data at the first rise
   always @(posedge wr) a_lat = addr_i;
   always @(negedge wr) if (rst_n_i) take(a_lat, dq_oe_i ? dq_i : ~dq_i);
   // busy while an internally timed job runs
   always @(go) begin : runner
      rdy_o = 1'b0;
      #(busy_ns);
      rdy_o = 1'b1;
   end
   // reset low aborts the job
   always @(negedge rst_n_i) begin
      disable runner;
      rdy_o = 1'b1;
      s     = 0;
      t_low = $realtime;
   end
   // only a long enough reset pulse leaves single pulse mode
   always @(posedge rst_n_i) if ($realtime - t_low >= 500.0) sp = 1'b0;
   // a released bus inverts its word on release and again on each address change
   always @(rd, addr_i) q = rd ? peek(addr_i) : ~q;
   assign #70 dq_o = q;
endmodule : flash_model

/* File: hw/flash_ctl_pkg.sv */
// constants, command codes and types for the flash mode controller
// How it works
// - only command sequences enter single-pulse mode
// - after enter code, one pulse programs one word
// - single-pulse mode ends on 500 ns reset
// - keep enter code out of product software
// - address at later fall, data at first rise
package flash_ctl_pkg;
   // array shape
   localparam int ADDR_W      = 20;
   localparam int DATA_W      = 16;
   localparam int NUM_SECTORS = 39;
   localparam int SMALL_BITS  = 12;
   localparam int LARGE_BITS  = 15;
   localparam int SECT_W      = 6;
   // timing in ns and derived cycles at 125 MHz
   localparam int CLK_NS      = 8;
   localparam int T_ACC_NS    = 70;
   localparam int T_WP_NS     = 48;
   localparam int T_RST_NS    = 500;
   localparam int T_BUSY_NS   = 200;
   localparam int SYNC_STAGES = 2;
   localparam logic [7:0] ACC_CYC  =
      8'((T_ACC_NS + CLK_NS - 1) / CLK_NS + SYNC_STAGES);
   localparam logic [7:0] WP_CYC   = 8'((T_WP_NS + CLK_NS - 1) / CLK_NS);
   localparam logic [7:0] RST_CYC  = 8'((T_RST_NS + CLK_NS - 1) / CLK_NS);
   localparam logic [7:0] BUSY_CYC = 8'((T_BUSY_NS + CLK_NS - 1) / CLK_NS);
   // command sequence addresses and codes, upper byte always zero
   localparam logic [19:0] UNLOCK_ADDR1   = 20'h00555;
   localparam logic [19:0] UNLOCK_ADDR2   = 20'h002AA;
   localparam logic [15:0] UNLOCK_DATA1   = 16'h00AA;
   localparam logic [15:0] UNLOCK_DATA2   = 16'h0055;
   localparam logic [15:0] CODE_PROGRAM   = 16'h00A0;
   localparam logic [15:0] CODE_ERASE     = 16'h0080;
   localparam logic [15:0] CODE_SECT_ERA  = 16'h0030;
   localparam logic [15:0] CODE_CHIP_ERA  = 16'h0010;
   localparam logic [15:0] CODE_SUSPEND   = 16'h00B0;
   localparam logic [15:0] CODE_RESUME    = 16'h0030;
   localparam logic [15:0] CODE_ENTER_SP  = 16'h0050;
   localparam logic [2:0]  STEPS_PROGRAM  = 3'h4;
   localparam logic [2:0]  STEPS_LONG     = 3'h6;
   localparam logic [2:0]  STEPS_SINGLE   = 3'h1;
   localparam logic [2:0]  STEP_OPCODE    = 3'h2;
   // host commands
   typedef enum logic [2:0] {
      OP_READ, OP_PROGRAM, OP_SECTOR_ERASE, OP_CHIP_ERASE,
      OP_SUSPEND, OP_RESUME, OP_ENTER_SP, OP_RESET
   } op_t;
   typedef enum logic [2:0] {
      ST_IDLE, ST_SETUP, ST_STROBE, ST_HOLD, ST_READ, ST_BUSY, ST_RESET
   } state_t;
endpackage : flash_ctl_pkg

/* File: hw/flash_mode_control.sv */
// host-side controller driving the flash pins from a command port
`timescale 1ns/1ps
module flash_mode_control #(
   parameter int ADDR_W = flash_ctl_pkg::ADDR_W,
   parameter int DATA_W = flash_ctl_pkg::DATA_W
) (
   // clock and reset
   input  wire logic                   CLK_I,
   input  wire logic                   RST_I,
   // command port
   input  wire logic                   CMD_VALID_I,
   input  wire flash_ctl_pkg::op_t     CMD_OP_I,
   input  wire logic [ADDR_W-1:0]      CMD_ADDR_I,
   input  wire logic [DATA_W-1:0]      CMD_DATA_I,
   input  wire logic [flash_ctl_pkg::NUM_SECTORS-1:0] PROTECT_I,
   output logic                        CMD_READY_O,
   // response port
   output logic                        RSP_VALID_O,
   output logic                        RSP_ERROR_O,
   output logic [DATA_W-1:0]           RSP_DATA_O,
   output logic                        SP_MODE_O,
   // flash pins
   output logic [ADDR_W-1:0]           FL_ADDR_O,
   output logic                        FL_CE_N_O,
   output logic                        FL_OUTPUT_GATE_N_O,
   output logic                        FL_WRITE_STROBE_N_O,
   output logic                        FL_RESET_N_O,
   output logic                        FL_VPP_EN_O,
   input  wire logic [DATA_W-1:0]      FL_DQ_I,
   output logic [DATA_W-1:0]           FL_DQ_O,
   output logic                        FL_DQ_OE_O,
   input  wire logic                   FL_RDY_I
);
   // sector index: eight 4K boot sectors, then 32K sectors
   function automatic logic [flash_ctl_pkg::SECT_W-1:0] sector_of(
      input logic [ADDR_W-1:0] a);
      logic [ADDR_W-1:0] big;
      big = a >> flash_ctl_pkg::LARGE_BITS;
      if (big == '0) begin
         sector_of = flash_ctl_pkg::SECT_W'(a >> flash_ctl_pkg::SMALL_BITS);
      end else begin
         sector_of = flash_ctl_pkg::SECT_W'(big + ADDR_W'(7));
      end
   endfunction : sector_of

   // one bus cycle of a command sequence: {address, data}
   function automatic logic [ADDR_W+DATA_W-1:0] seq_word(
      input flash_ctl_pkg::op_t op, input logic [2:0] step,
      input logic last, input logic [ADDR_W-1:0] a,
      input logic [DATA_W-1:0] d);
      logic [DATA_W-1:0] opc;
      opc = (op == flash_ctl_pkg::OP_PROGRAM) ?
            flash_ctl_pkg::CODE_PROGRAM : flash_ctl_pkg::CODE_ERASE;
      seq_word = {flash_ctl_pkg::UNLOCK_ADDR1, flash_ctl_pkg::UNLOCK_DATA1};
      if (last) begin
         unique case (op)
            flash_ctl_pkg::OP_SECTOR_ERASE:
               seq_word = {a, flash_ctl_pkg::CODE_SECT_ERA};
            flash_ctl_pkg::OP_CHIP_ERASE:
               seq_word = {flash_ctl_pkg::UNLOCK_ADDR1,
                           flash_ctl_pkg::CODE_CHIP_ERA};
            flash_ctl_pkg::OP_SUSPEND:
               seq_word = {a, flash_ctl_pkg::CODE_SUSPEND};
            flash_ctl_pkg::OP_RESUME:
               seq_word = {a, flash_ctl_pkg::CODE_RESUME};
            flash_ctl_pkg::OP_ENTER_SP:
               seq_word = {flash_ctl_pkg::UNLOCK_ADDR1,
                           flash_ctl_pkg::CODE_ENTER_SP};
            default: seq_word = {a, d}; // program word
         endcase
      end else if (step == 3'h1 || step == 3'h4) begin
         seq_word = {flash_ctl_pkg::UNLOCK_ADDR2, flash_ctl_pkg::UNLOCK_DATA2};
      end else if (step == flash_ctl_pkg::STEP_OPCODE) begin
         seq_word = {flash_ctl_pkg::UNLOCK_ADDR1, opc};
      end
   endfunction : seq_word

   flash_ctl_pkg::state_t  state_reg;
   flash_ctl_pkg::op_t     op_reg;
   logic [7:0]             cnt_reg;
   logic [2:0]             step_reg;
   logic [2:0]             nsteps_reg;
   logic [ADDR_W-1:0]      addr_reg;
   logic [DATA_W-1:0]      data_reg;
   logic                   sp_mode_reg;
   logic                   wait_reg;
   logic [DATA_W-1:0]      dq_s1_reg;
   logic [DATA_W-1:0]      dq_s2_reg;
   logic                   rdy_s1_reg;
   logic                   rdy_s2_reg;

   // pins come from outside; two flops before any use
   always_ff @(posedge CLK_I) begin
      dq_s1_reg  <= FL_DQ_I;
      dq_s2_reg  <= dq_s1_reg;
      rdy_s1_reg <= FL_RDY_I;
      rdy_s2_reg <= rdy_s1_reg;
   end

   // command decode
   wire logic is_prog  = (CMD_OP_I == flash_ctl_pkg::OP_PROGRAM);
   wire logic is_serase = (CMD_OP_I == flash_ctl_pkg::OP_SECTOR_ERASE);
   wire logic is_erase = is_serase ||
                         (CMD_OP_I == flash_ctl_pkg::OP_CHIP_ERASE);
   wire logic is_susp  = (CMD_OP_I == flash_ctl_pkg::OP_SUSPEND) ||
                         (CMD_OP_I == flash_ctl_pkg::OP_RESUME);
   // mirror lockout so a refused write never reaches the pins
   wire logic prot_hit = (is_prog || is_serase) &&
                         PROTECT_I[sector_of(CMD_ADDR_I)];
   // flash would program erase codes as data in this mode
   wire logic sp_refuse = sp_mode_reg && (is_erase || is_susp ||
                          CMD_OP_I == flash_ctl_pkg::OP_ENTER_SP);
   wire logic refuse   = prot_hit || sp_refuse;
   wire logic take     = CMD_VALID_I && (state_reg == flash_ctl_pkg::ST_IDLE);
   // prefix dropped once single-pulse mode is on
   wire logic [2:0] nsteps_w =
      (is_prog && sp_mode_reg) || is_susp ? flash_ctl_pkg::STEPS_SINGLE :
      is_prog ? flash_ctl_pkg::STEPS_PROGRAM :
      flash_ctl_pkg::STEPS_LONG;
   wire logic needs_wait = is_prog || is_erase ||
                           (CMD_OP_I == flash_ctl_pkg::OP_SUSPEND);
   wire logic last_step = (step_reg == nsteps_reg - 3'h1);
   wire logic [ADDR_W+DATA_W-1:0] word_w =
      seq_word(op_reg, step_reg, last_step, addr_reg, data_reg);
   wire logic done_ok = (state_reg == flash_ctl_pkg::ST_BUSY) &&
                        (cnt_reg == '0) && rdy_s2_reg;
   wire logic finish  = done_ok ||
      ((state_reg == flash_ctl_pkg::ST_HOLD) && last_step && !wait_reg);

   // sequencer; pins idle and released while RST_I is high
   always_ff @(posedge CLK_I) begin
      if (RST_I) begin
         state_reg           <= flash_ctl_pkg::ST_IDLE;
         op_reg              <= flash_ctl_pkg::OP_READ;
         cnt_reg             <= '0;
         step_reg            <= '0;
         nsteps_reg          <= flash_ctl_pkg::STEPS_SINGLE;
         addr_reg            <= '0;
         data_reg            <= '0;
         sp_mode_reg         <= 1'b0;
         wait_reg            <= 1'b0;
         CMD_READY_O         <= 1'b1;
         RSP_VALID_O         <= 1'b0;
         RSP_ERROR_O         <= 1'b0;
         RSP_DATA_O          <= '0;
         FL_ADDR_O           <= '0;
         FL_CE_N_O           <= 1'b1;
         FL_OUTPUT_GATE_N_O  <= 1'b1;
         FL_WRITE_STROBE_N_O <= 1'b1;
         FL_RESET_N_O        <= 1'b1;
         FL_VPP_EN_O         <= 1'b0;
         FL_DQ_O             <= '0;
         FL_DQ_OE_O          <= 1'b0;
      end else begin
         RSP_VALID_O <= 1'b0;
         unique case (state_reg)
            flash_ctl_pkg::ST_IDLE: if (take) begin
               op_reg     <= CMD_OP_I;
               addr_reg   <= CMD_ADDR_I;
               data_reg   <= CMD_DATA_I;
               step_reg   <= '0;
               nsteps_reg <= nsteps_w;
               wait_reg   <= needs_wait;
               RSP_ERROR_O <= refuse;
               if (refuse) begin
                  RSP_VALID_O <= 1'b1;
               end else if (CMD_OP_I == flash_ctl_pkg::OP_READ) begin
                  CMD_READY_O        <= 1'b0;
                  FL_ADDR_O          <= CMD_ADDR_I;
                  FL_CE_N_O          <= 1'b0;
                  FL_OUTPUT_GATE_N_O <= 1'b0;
                  cnt_reg            <= flash_ctl_pkg::ACC_CYC;
                  state_reg          <= flash_ctl_pkg::ST_READ;
               end else if (CMD_OP_I == flash_ctl_pkg::OP_RESET) begin
                  CMD_READY_O  <= 1'b0;
                  FL_RESET_N_O <= 1'b0;
                  cnt_reg      <= flash_ctl_pkg::RST_CYC;
                  state_reg    <= flash_ctl_pkg::ST_RESET;
               end else begin
                  CMD_READY_O <= 1'b0;
                  // supply raised only for real writes
                  FL_VPP_EN_O <= FL_VPP_EN_O || is_prog || is_erase;
                  state_reg   <= flash_ctl_pkg::ST_SETUP;
               end
            end
            flash_ctl_pkg::ST_SETUP: begin
               // address and select first, strobe falls later
               {FL_ADDR_O, FL_DQ_O} <= word_w;
               FL_DQ_OE_O <= 1'b1;
               FL_CE_N_O  <= 1'b0;
               cnt_reg    <= flash_ctl_pkg::WP_CYC;
               state_reg  <= flash_ctl_pkg::ST_STROBE;
            end
            flash_ctl_pkg::ST_STROBE: begin
               if (cnt_reg == '0) begin
                  FL_WRITE_STROBE_N_O <= 1'b1;
                  state_reg           <= flash_ctl_pkg::ST_HOLD;
               end else begin
                  FL_WRITE_STROBE_N_O <= 1'b0;
                  cnt_reg             <= cnt_reg - 8'h01;
               end
            end
            flash_ctl_pkg::ST_HOLD: begin
               // data held one cycle past the strobe rise
               FL_CE_N_O  <= 1'b1;
               FL_DQ_OE_O <= 1'b0;
               step_reg   <= step_reg + 3'h1;
               cnt_reg    <= flash_ctl_pkg::BUSY_CYC;
               if (!last_step) begin
                  state_reg <= flash_ctl_pkg::ST_SETUP;
               end else if (wait_reg) begin
                  state_reg <= flash_ctl_pkg::ST_BUSY;
               end else begin
                  state_reg <= flash_ctl_pkg::ST_IDLE;
                  if (op_reg == flash_ctl_pkg::OP_ENTER_SP) begin
                     sp_mode_reg <= 1'b1;
                     FL_VPP_EN_O <= 1'b1;
                  end
               end
            end
            flash_ctl_pkg::ST_BUSY: begin
               // let ready fall before trusting its rise
               if (cnt_reg != '0) begin
                  cnt_reg <= cnt_reg - 8'h01;
               end else if (rdy_s2_reg) begin
                  FL_VPP_EN_O <= sp_mode_reg;
                  state_reg   <= flash_ctl_pkg::ST_IDLE;
               end
            end
            flash_ctl_pkg::ST_READ: begin
               if (cnt_reg == '0) begin
                  RSP_DATA_O         <= dq_s2_reg;
                  RSP_VALID_O        <= 1'b1;
                  CMD_READY_O        <= 1'b1;
                  FL_CE_N_O          <= 1'b1;
                  FL_OUTPUT_GATE_N_O <= 1'b1;
                  state_reg          <= flash_ctl_pkg::ST_IDLE;
               end else begin
                  cnt_reg <= cnt_reg - 8'h01;
               end
            end
            flash_ctl_pkg::ST_RESET: begin
               if (cnt_reg == '0) begin
                  FL_RESET_N_O <= 1'b1;
                  sp_mode_reg  <= 1'b0;
                  FL_VPP_EN_O  <= 1'b0;
                  RSP_VALID_O  <= 1'b1;
                  CMD_READY_O  <= 1'b1;
                  state_reg    <= flash_ctl_pkg::ST_IDLE;
               end else begin
                  cnt_reg <= cnt_reg - 8'h01;
               end
            end
         endcase
         if (finish) begin
            RSP_VALID_O <= 1'b1;
            CMD_READY_O <= 1'b1;
         end
      end
   end

   assign SP_MODE_O = sp_mode_reg;

   // helper: length of the current reset pulse
   logic [7:0] rst_low_reg;
   always_ff @(posedge CLK_I) begin
      if (RST_I || FL_RESET_N_O) rst_low_reg <= '0;
      else if (rst_low_reg != 8'hFF) rst_low_reg <= rst_low_reg + 8'h01;
   end
   wire logic cmd_code_cycle = !(last_step &&
      op_reg == flash_ctl_pkg::OP_PROGRAM);

   a_reset_start: assert property (@(posedge CLK_I)
      $past(RST_I) && !RST_I |-> CMD_READY_O && !SP_MODE_O && FL_RESET_N_O)
      else $error("controller not idle after reset");
   a_read_gate: assert property (@(posedge CLK_I) disable iff (RST_I)
      !FL_OUTPUT_GATE_N_O |-> FL_WRITE_STROBE_N_O && !FL_CE_N_O
         && !FL_DQ_OE_O)
      else $error("read gate with write or drive");
   a_strobe_in_ce: assert property (@(posedge CLK_I) disable iff (RST_I)
      $fell(FL_WRITE_STROBE_N_O) |-> !FL_CE_N_O && $past(!FL_CE_N_O)
         && FL_DQ_OE_O)
      else $error("strobe fell without select setup");
   a_upper_zero: assert property (@(posedge CLK_I) disable iff (RST_I)
      !FL_WRITE_STROBE_N_O && cmd_code_cycle |-> FL_DQ_O[15:8] == 8'h00)
      else $error("command code upper byte not zero");
   a_reset_width: assert property (@(posedge CLK_I) disable iff (RST_I)
      $rose(FL_RESET_N_O) |-> !SP_MODE_O &&
         $past(rst_low_reg) >= flash_ctl_pkg::RST_CYC)
      else $error("reset pulse too short or mode kept");
   a_sp_refuse: assert property (@(posedge CLK_I) disable iff (RST_I)
      take && sp_mode_reg && is_erase |=> RSP_VALID_O && RSP_ERROR_O
         && state_reg == flash_ctl_pkg::ST_IDLE)
      else $error("erase accepted in single-pulse mode");
   a_prot_refuse: assert property (@(posedge CLK_I) disable iff (RST_I)
      take && prot_hit |=> RSP_ERROR_O ##1 FL_WRITE_STROBE_N_O)
      else $error("protected sector not refused");
   a_vpp_idle: assert property (@(posedge CLK_I) disable iff (RST_I)
      state_reg == flash_ctl_pkg::ST_IDLE && !sp_mode_reg |-> !FL_VPP_EN_O)
      else $error("program supply left raised");
   a_wait_ready: assert property (@(posedge CLK_I) disable iff (RST_I)
      $fell(FL_CE_N_O) ##0 wait_reg |-> !RSP_VALID_O[*2])
      else $error("response during write cycle");
   a_done_ready: assert property (@(posedge CLK_I) disable iff (RST_I)
      $past(state_reg == flash_ctl_pkg::ST_BUSY) && RSP_VALID_O
         |-> $past(rdy_s2_reg) && $past(cnt_reg) == 8'h00)
      else $error("write done before ready");
   c_read: cover property (@(posedge CLK_I)
      RSP_VALID_O && op_reg == flash_ctl_pkg::OP_READ);
   c_program: cover property (@(posedge CLK_I) done_ok && !sp_mode_reg);
   c_sp_write: cover property (@(posedge CLK_I) done_ok && sp_mode_reg);
   c_sp_exit: cover property (@(posedge CLK_I) $fell(SP_MODE_O));
endmodule : flash_mode_control
